// File: rtl/sign_test_branch_unit.sv
// Branch resolution for register-against-zero branches with delay slots.
// Assumes an in-order issue stage presenting one instruction per enabled cycle,
// register values read in the same cycle, and an exception flag for the slot.
`timescale 1ns/1ps
`include "sign_test_branch_defs.svh"
module sign_test_branch_unit #(
  parameter int XLEN = 64
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  // Issue stage
  input  wire logic                            issueValid,
  input  wire logic [31:0]                     instr,
  input  wire logic [XLEN-1:0]                 issuePc,
  input  wire logic [XLEN-1:0]                 srcVal,
  // Delay-slot exception report, same cycle as slot issue
  input  wire logic                            slotException,
  // Decode result
  output logic                                 isBranchReg,
  // Program counter steering
  output logic                                 redirectReg,
  output logic [XLEN-1:0]                      redirectPcReg,
  output logic                                 cancelSlotReg,
  // Restart after delay-slot fault
  output logic                                 restartReg,
  output logic [XLEN-1:0]                      restartPcReg,
  // Link register write
  output sign_test_branch_pkg::link_write_t    linkWriteReg
);
  import sign_test_branch_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SLOT
  } state_t;

  decoded_t         dec;
  logic             taken;
  logic [XLEN-1:0]  target;
  logic [XLEN-1:0]  linkAddr;
  logic [XLEN-1:0]  srcMasked;
  logic             branchIssue;

  state_t           state_reg;
  state_t           state_next;
  logic             takenHeld_reg;
  logic             likelyHeld_reg;
  logic [XLEN-1:0]  targetHeld_reg;
  logic [XLEN-1:0]  branchPcHeld_reg;

  branch_decode u_branch_decode (
    .instr (instr),
    .dec   (dec)
  );

  // Zero register always reads zero, whatever the file port shows
  assign srcMasked = (dec.srcReg == `ZERO_REG) ? '0 : srcVal;

  branch_condition #(
    .XLEN (XLEN)
  ) u_branch_condition (
    .kind     (dec.kind),
    .srcVal   (srcMasked),
    .imm      (dec.imm),
    .branchPc (issuePc),
    .taken    (taken),
    .target   (target),
    .linkAddr (linkAddr)
  );

  // A branch seen while a slot is pending is the unsupported slot case;
  // it is ignored as a branch, which is one acceptable outcome
  assign branchIssue = issueValid && dec.isBranch && (state_reg == ST_IDLE);

  // Two states: waiting for a branch, waiting for its delay slot
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (branchIssue) begin
          state_next = ST_SLOT;
        end
      end
      ST_SLOT: begin
        if (issueValid) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Condition and target are captured in the branch's own cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      takenHeld_reg    <= 1'b0;
      likelyHeld_reg   <= 1'b0;
      targetHeld_reg   <= '0;
      branchPcHeld_reg <= '0;
    end else if (branchIssue) begin
      takenHeld_reg    <= taken;
      likelyHeld_reg   <= dec.likely;
      targetHeld_reg   <= target;
      branchPcHeld_reg <= issuePc;
    end
  end

  // Decode flag registered so every output leaves a flip-flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isBranchReg <= 1'b0;
    end else begin
      isBranchReg <= branchIssue;
    end
  end

  // Redirect fires only once the slot has issued and completed cleanly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      redirectReg   <= 1'b0;
      redirectPcReg <= XLEN'(`PC_RESET);
    end else begin
      redirectReg <= 1'b0;
      if (state_reg == ST_SLOT && issueValid && !slotException && takenHeld_reg) begin
        redirectReg   <= 1'b1;
        redirectPcReg <= targetHeld_reg;
      end
    end
  end

  // Likely, not taken: the slot is nullified and fetch simply runs on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cancelSlotReg <= 1'b0;
    end else begin
      cancelSlotReg <= 1'b0;
      if (state_reg == ST_SLOT && issueValid && likelyHeld_reg && !takenHeld_reg) begin
        cancelSlotReg <= 1'b1;
      end
    end
  end

  // A faulting slot resumes at the branch so it is tested again;
  // a cancelled slot cannot fault, so nullification takes precedence
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restartReg   <= 1'b0;
      restartPcReg <= XLEN'(`PC_RESET);
    end else begin
      restartReg <= 1'b0;
      if (state_reg == ST_SLOT && issueValid && slotException
          && !(likelyHeld_reg && !takenHeld_reg)) begin
        restartReg   <= 1'b1;
        restartPcReg <= branchPcHeld_reg;
      end
    end
  end

  // Link written unconditionally for call forms; re-execution after a
  // slot fault rewrites the same value, so testing r31 would be unsafe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linkWriteReg <= '0;
    end else begin
      linkWriteReg.valid <= branchIssue && (dec.kind == KIND_CALL);
      linkWriteReg.addr  <= `LINK_REG;
      linkWriteReg.data  <= linkAddr;
    end
  end

endmodule

// File: rtl/sign_test_branch_defs.svh
// Constants for the sign-test branch unit: opcodes, field positions, offsets.
// Assumes a 32-bit instruction word and a 64-bit register and address width.
// Functional notes
// - The target is the 16-bit immediate shifted left two places as an 18-bit signed value, added to the delay-slot address.
// - The nonnegative tests are true exactly when the tested register's top bit is clear.
// - The positive tests are true only when the top bit is clear and the value is not zero.
// - A true condition lets the one delay-slot instruction complete before fetch moves to the target.
// - A likely form with a false condition cancels the delay-slot instruction and continues after it.
// - The call forms write the branch address plus 8 into register 31.
// - An exception in the delay slot makes execution resume at the branch, not at the slot.
// - The call-on-nonnegative form is primary opcode 000001 with 10001 in bits 20 to 16 and a 16-bit immediate.
// - The likely call-on-nonnegative form is primary opcode 000001 with 10011 in bits 20 to 16.
// - The call-on-nonnegative form testing the zero register acts as an unconditional relative call.
`ifndef SIGN_TEST_BRANCH_DEFS_SVH
`define SIGN_TEST_BRANCH_DEFS_SVH

`define OPC_HI          31
`define OPC_LO          26
`define SRC_HI          25
`define SRC_LO          21
`define SEL_HI          20
`define SEL_LO          16
`define IMM_HI          15
`define IMM_LO          0
`define OPC_REGISTER_IMMEDIATE_OPCODE_CLASS      6'h01
`define OPC_POS         6'h07
`define OPC_POS_LIKELY  6'h17
`define SEL_NONNEG      5'h01
`define SEL_NONNEG_L    5'h03
`define SEL_CALL        5'h11
`define SEL_CALL_L      5'h13
`define SEL_ZERO        5'h00
`define LINK_REG        5'h1F
`define ZERO_REG        5'h00
`define LINK_OFFSET     64'h0000_0000_0000_0008
`define SLOT_OFFSET     64'h0000_0000_0000_0004
`define PC_RESET        64'h0000_0000_0000_0000

`endif

// File: rtl/sign_test_branch_pkg.sv
// Types shared by the sign-test branch unit and its helpers.
// Assumes the defs header is compiled alongside.
package sign_test_branch_pkg;

  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_NONNEG,
    KIND_POSITIVE,
    KIND_CALL
  } branch_kind_t;

  // Decoded branch fields travel together
  typedef struct packed {
    logic         isBranch;
    branch_kind_t kind;
    logic         likely;
    logic [4:0]   srcReg;
    logic [15:0]  imm;
  } decoded_t;

  // Register 31 write request
  typedef struct packed {
    logic        valid;
    logic [4:0]  addr;
    logic [63:0] data;
  } link_write_t;

endpackage

// File: rtl/branch_decode.sv
// Combinational decoder for the sign-test branch family.
// Assumes a 32-bit instruction word from the fetch stage on the same clock.
`timescale 1ns/1ps
`include "sign_test_branch_defs.svh"
module branch_decode (
  // Instruction in
  input  wire logic [31:0]                 instr,
  // Decoded fields out
  output sign_test_branch_pkg::decoded_t   dec
);
  import sign_test_branch_pkg::*;

  logic [5:0] opc;
  logic [4:0] sel;

  assign opc = instr[`OPC_HI:`OPC_LO];
  assign sel = instr[`SEL_HI:`SEL_LO];

  // Unknown selector codes fall through as not a branch of this family
  always_comb begin
    dec        = '0;
    dec.srcReg = instr[`SRC_HI:`SRC_LO];
    dec.imm    = instr[`IMM_HI:`IMM_LO];
    dec.kind   = KIND_NONE;
    if (opc == `OPC_REGISTER_IMMEDIATE_OPCODE_CLASS) begin
      unique case (sel)
        `SEL_NONNEG: begin
          dec.kind = KIND_NONNEG;
        end
        `SEL_NONNEG_L: begin
          dec.kind   = KIND_NONNEG;
          dec.likely = 1'b1;
        end
        `SEL_CALL: begin
          dec.kind = KIND_CALL;
        end
        `SEL_CALL_L: begin
          dec.kind   = KIND_CALL;
          dec.likely = 1'b1;
        end
        default: begin
          dec.kind = KIND_NONE;
        end
      endcase
    end else if ((opc == `OPC_POS) || (opc == `OPC_POS_LIKELY)) begin
      if (sel == `SEL_ZERO) begin
        dec.kind   = KIND_POSITIVE;
        dec.likely = (opc == `OPC_POS_LIKELY);
      end
    end
    dec.isBranch = (dec.kind != KIND_NONE);
  end

endmodule

// File: rtl/branch_condition.sv
// Sign test and target adder for one branch.
// Assumes operands are stable in the branch's issue cycle.
`timescale 1ns/1ps
`include "sign_test_branch_defs.svh"
module branch_condition #(
  parameter int XLEN = 64
) (
  // Operands
  input  sign_test_branch_pkg::branch_kind_t kind,
  input  wire logic [XLEN-1:0]               srcVal,
  input  wire logic [15:0]                   imm,
  input  wire logic [XLEN-1:0]               branchPc,
  // Results
  output logic                               taken,
  output logic [XLEN-1:0]                    target,
  output logic [XLEN-1:0]                    linkAddr
);
  import sign_test_branch_pkg::*;

  logic             signClear;
  logic [17:0]      offset18;
  logic [XLEN-1:0]  slotPc;

  assign signClear = ~srcVal[XLEN-1];

  // Condition per kind; the zero register reads zero, so a call on it always goes
  always_comb begin
    unique case (kind)
      KIND_NONNEG:   taken = signClear;
      KIND_CALL:     taken = signClear;
      KIND_POSITIVE: taken = signClear && (srcVal != '0);
      default:       taken = 1'b0;
    endcase
  end

  // Shift then sign-extend from 18 bits onto the delay-slot address
  assign offset18 = {imm, 2'b00};
  assign slotPc   = branchPc + XLEN'(`SLOT_OFFSET);
  assign target   = slotPc + {{(XLEN-18){offset18[17]}}, offset18};
  assign linkAddr = branchPc + XLEN'(`LINK_OFFSET);

endmodule

// File: testbench/sign_test_branch_unit_monitor.sv
// Assertion checker for the sign-test branch unit, bound onto its ports.
// Assumes the slot is the next issued instruction after an accepted branch.
`timescale 1ns/1ps
module sign_test_branch_unit_monitor #(
  parameter int XLEN = 64
) (
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic                      issueValid,
  input wire logic [31:0]               instr,
  input wire logic [XLEN-1:0]           issuePc,
  input wire logic [XLEN-1:0]           srcVal,
  input wire logic                      slotException,
  input wire logic                      isBranchReg,
  input wire logic                      redirectReg,
  input wire logic [XLEN-1:0]           redirectPcReg,
  input wire logic                      cancelSlotReg,
  input wire logic                      restartReg,
  input wire logic [XLEN-1:0]           restartPcReg,
  input sign_test_branch_pkg::link_write_t linkWriteReg
);
  import sign_test_branch_pkg::*;
  logic [31:0]     pInstr;
  logic [XLEN-1:0] pPc, pSrc, sv, tgtCap, pcCap;
  logic            cond, lik, condCap, likCap;

  // Last issued instruction; the branch's own copy is live while isBranchReg is up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pInstr <= '0;
      pPc <= '0;
      pSrc <= '0;
    end else if (issueValid) begin
      pInstr <= instr;
      pPc <= issuePc;
      pSrc <= srcVal;
    end
  end

  // Reference sign test; the zero register reads as zero whatever srcVal says
  assign sv = (pInstr[25:21] == 5'h00) ? '0 : pSrc;
  assign cond = !sv[XLEN-1] && (pInstr[31:26] == 6'h01 || sv != '0);
  assign lik = (pInstr[31:26] == 6'h01) ? pInstr[17] : pInstr[30];

  // Branch facts kept until the slot resolves, since the slot may come late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgtCap <= '0;
      pcCap <= '0;
      condCap <= 1'b0;
      likCap <= 1'b0;
    end else if (isBranchReg) begin
      tgtCap <= pPc + 4 + {{(XLEN-18){pInstr[15]}}, pInstr[15:0], 2'b00};
      pcCap <= pPc;
      condCap <= cond;
      likCap <= lik;
    end
  end

  property p_link_data;
    @(posedge clk) disable iff (!arst_n)
    linkWriteReg.valid |-> linkWriteReg.addr == 5'h1F && linkWriteReg.data == pPc + 8;
  endproperty
  a_link_data: assert property (p_link_data) else $error("bad link write");
  property p_link_forms;
    @(posedge clk) disable iff (!arst_n)
    isBranchReg && pInstr[31:26] == 6'h01 && pInstr[20] |-> linkWriteReg.valid;
  endproperty
  a_link_forms: assert property (p_link_forms) else $error("link write missing");
  property p_link_only;
    @(posedge clk) disable iff (!arst_n)
    linkWriteReg.valid |-> isBranchReg && pInstr[20];
  endproperty
  a_link_only: assert property (p_link_only) else $error("stray link write");
  property p_decode;
    @(posedge clk) disable iff (!arst_n)
    isBranchReg |-> $past(issueValid) && pInstr[31:26] inside {6'h01, 6'h07, 6'h17};
  endproperty
  a_decode: assert property (p_decode) else $error("branch flag without branch");
  property p_redirect_tgt;
    @(posedge clk) disable iff (!arst_n)
    redirectReg |-> condCap && redirectPcReg == tgtCap;
  endproperty
  a_redirect_tgt: assert property (p_redirect_tgt) else $error("bad redirect");
  property p_redirect_after_slot;
    @(posedge clk) disable iff (!arst_n)
    redirectReg |-> $past(issueValid) && !isBranchReg ##1 !redirectReg;
  endproperty
  a_redirect_after_slot: assert property (p_redirect_after_slot) else $error("redirect timing");
  property p_cancel;
    @(posedge clk) disable iff (!arst_n)
    cancelSlotReg |-> likCap && !condCap && !redirectReg && !restartReg;
  endproperty
  a_cancel: assert property (p_cancel) else $error("bad cancel");
  property p_restart;
    @(posedge clk) disable iff (!arst_n)
    restartReg |-> restartPcReg == pcCap && !redirectReg && $past(slotException);
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
endmodule

bind sign_test_branch_unit sign_test_branch_unit_monitor #(.XLEN(XLEN)) u_sign_test_branch_unit_monitor (
  .clk(clk), .arst_n(arst_n), .issueValid(issueValid), .instr(instr), .issuePc(issuePc),
  .srcVal(srcVal), .slotException(slotException), .isBranchReg(isBranchReg),
  .redirectReg(redirectReg), .redirectPcReg(redirectPcReg), .cancelSlotReg(cancelSlotReg),
  .restartReg(restartReg), .restartPcReg(restartPcReg), .linkWriteReg(linkWriteReg));

// File: testbench/sign_test_branch_unit_tb_top.sv
// Self-checking bench for the sign-test branch unit.
// Assumes design, package and monitor are compiled first.
`timescale 1ns/1ps
module sign_test_branch_unit_tb_top;
  import sign_test_branch_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, issueValid = 1'b0, slotException = 1'b0;
  logic [31:0] instr = 32'h0000_0000;
  logic [63:0] issuePc = 64'h0, srcVal = 64'h0, redirectPcReg, restartPcReg;
  logic        isBranchReg, redirectReg, cancelSlotReg, restartReg;
  link_write_t linkWriteReg;
  logic [67:0] expQ[$];
  int          fails = 0, totalChecks = 0;
  int          slotGap = 0;
  logic [10:0] forms[6] = '{{6'h01, 5'h01}, {6'h01, 5'h03}, {6'h01, 5'h11}, {6'h01, 5'h13},
                            {6'h07, 5'h00}, {6'h17, 5'h00}};
  logic [63:0] vals[5] = '{64'h0, 64'h1, 64'h7FFF_FFFF_FFFF_FFFF, 64'h8000_0000_0000_0000,
                           64'hFFFF_FFFF_FFFF_FFFF};

  always #25 clk = ~clk;

  sign_test_branch_unit u_sign_test_branch_unit (.clk(clk), .arst_n(arst_n),
    .issueValid(issueValid), .instr(instr), .issuePc(issuePc), .srcVal(srcVal),
    .slotException(slotException), .isBranchReg(isBranchReg), .redirectReg(redirectReg),
    .redirectPcReg(redirectPcReg), .cancelSlotReg(cancelSlotReg), .restartReg(restartReg),
    .restartPcReg(restartPcReg), .linkWriteReg(linkWriteReg));

  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // An output with nothing expected is compared against its own inverse
  task automatic take(input logic [67:0] seen);
    if (expQ.size() == 0) check(seen, ~seen);
    else check(seen, expQ.pop_front());
  endtask

  // Sample mid-cycle so the registered pulses have settled
  always @(negedge clk) if (arst_n) begin
    if (isBranchReg === 1'b1) take(68'h0);
    if (linkWriteReg.valid === 1'b1) take({4'h1, linkWriteReg.data});
    if (redirectReg === 1'b1) take({4'h2, redirectPcReg});
    if (cancelSlotReg === 1'b1) take({4'h3, 64'h0});
    if (restartReg === 1'b1) take({4'h4, restartPcReg});
  end

  // One branch and its slot, slotGap idle cycles apart; the expected pulses are queued first
  task automatic br(input logic [10:0] f, input logic [4:0] rf, input logic [63:0] v,
                    input logic exc);
    logic [15:0] imm;
    logic [63:0] pc, sv, tgt;
    logic        pos, cond, lik, fam;
    imm = 16'($urandom);
    pc = {32'($urandom), 30'($urandom), 2'b00};
    sv = (rf == 5'h00) ? 64'h0 : v;
    pos = (f[10:5] != 6'h01);
    fam = pos ? (f[4:0] == 5'h00) : (f[4:0] inside {5'h01, 5'h03, 5'h11, 5'h13});
    cond = !sv[63] && (!pos || sv != 64'h0);
    lik = pos ? f[9] : f[1];
    tgt = pc + 64'h4 + {{46{imm[15]}}, imm, 2'b00};
    if (fam) expQ.push_back(68'h0);
    if (fam && !pos && f[4]) expQ.push_back({4'h1, pc + 64'h8});
    if (fam && lik && !cond) expQ.push_back({4'h3, 64'h0});
    else if (fam && exc) expQ.push_back({4'h4, pc});
    else if (fam && cond) expQ.push_back({4'h2, tgt});
    @(posedge clk);
    issueValid <= 1'b1;
    instr <= {f[10:5], rf, f[4:0], imm};
    issuePc <= pc;
    srcVal <= v;
    slotException <= 1'b0;
    @(posedge clk);
    // Idle cycles between a branch and its slot must not trigger the redirect
    if (slotGap > 0) begin
      issueValid <= 1'b0;
      repeat (slotGap) @(posedge clk);
      issueValid <= 1'b1;
    end
    instr <= 32'h0000_0000;
    issuePc <= pc + 64'h4;
    srcVal <= 64'($urandom);
    slotException <= exc & fam;
  endtask

  task automatic finishTest();
    $display("checks=%0d mismatches=%0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finishTest();
  end

  // Register 31 is never the tested source of a call form
  initial begin
    void'($urandom(32'hf71c));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    foreach (forms[i]) foreach (vals[j]) for (int e = 0; e < 2; e++) begin
      br(forms[i], 5'($urandom_range(30, 1)), vals[j], e[0]);
    end
    $display("test forms done");
    br(forms[2], 5'h00, vals[4], 1'b0);
    br(forms[3], 5'h00, vals[3], 1'b1);
    br({6'h01, 5'h00}, 5'h04, vals[4], 1'b0);
    br({6'h07, 5'h02}, 5'h04, vals[1], 1'b0);
    $display("test zero source and refused done");
    for (int k = 0; k < 40; k++) begin
      slotGap = $urandom_range(2);
      br(forms[$urandom_range(5)], 5'($urandom_range(30, 1)), 64'($urandom) << 32,
         1'($urandom));
    end
    @(posedge clk);
    issueValid <= 1'b0;
    slotException <= 1'b0;
    repeat (4) @(posedge clk);
    check(68'(expQ.size()), 68'h0);
    $display("test random done");
    finishTest();
  end
endmodule
